// ### design/cts_sequencer.sv
// Purpose: trigger and timing sequencer for a dual-spectrum ccd camera
// Assumes: one 25 MHz clock, classic wishbone slave, async trigger pin
// Notes: exposure and readout times are counted in clock cycles of CLOCK_I, the delay in 10 ns steps
`timescale 1ns/100ps
`include "cts_cfg.svh"
module cts_sequencer
	import cts_pkg::*;
#(
	parameter int CLK_HZ = `CTS_CLK_HZ
) (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [`CTS_ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic TRIG_IN_I,
	output logic TRIG_OUT0_O,
	output logic TRIG_OUT1_O
);
	localparam int DSTEP_NS = `CTS_DELAY_STEP_NS;
	localparam int SH0 = (`CTS_SHIFT_NS_0 * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SH1 = (`CTS_SHIFT_NS_1 * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SH2 = (`CTS_SHIFT_NS_2 * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SH3 = (`CTS_SHIFT_NS_3 * (CLK_HZ / 1000000) + 999) / 1000;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [2:0] resp_r;
	logic edge_fall_r;
	logic [1:0] rate_r;
	logic large_r;
	logic [7:0] rows_r;
	logic [15:0] accum_r;
	logic [15:0] frames_r;
	logic [31:0] delay_r;
	logic [31:0] expose_r;
	logic [31:0] readout_r;
	cts_trigout_s to0_r;
	cts_trigout_s to1_r;
	logic start_r;
	logic abort_r;
	logic dropped_r;
	logic wb_ack_r;
	logic [31:0] wb_dat_r;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rows_max;
	logic [7:0] rows_wr;
	cts_state_e state_r;
	cts_status_s stat;
	logic [15:0] frame_r;

	assign wr_hit = WB_CYC_I && WB_STB_I && WB_WE_I && !wb_ack_r;
	assign rd_hit = WB_CYC_I && WB_STB_I && !WB_WE_I && !wb_ack_r;
	assign rows_max = large_r ? `CTS_ROWS_MAX_LARGE : `CTS_ROWS_MAX_SMALL;
	assign rows_wr = (WB_DAT_I[7:0] == 8'h00) ? 8'h01 :
		(WB_DAT_I[7:0] > rows_max) ? rows_max : WB_DAT_I[7:0];

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wb_ack_r <= 1'b0;
		end else begin
			wb_ack_r <= WB_CYC_I && WB_STB_I && !wb_ack_r;
		end
	end
	assign WB_ACK_O = wb_ack_r;

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			resp_r <= 3'h0;
			edge_fall_r <= 1'b0;
			rate_r <= 2'h0;
			large_r <= 1'b0;
			rows_r <= `CTS_RST_ROWS;
			accum_r <= `CTS_RST_ACCUM;
			frames_r <= `CTS_RST_FRAMES;
			delay_r <= 32'h0000_0000;
			expose_r <= `CTS_RST_EXPOSE;
			readout_r <= `CTS_RST_READOUT;
			to0_r <= '{sel: CTS_SEL_ACQ, invert: 1'b0};
			to1_r <= '{sel: CTS_SEL_ACQ, invert: 1'b0};
			start_r <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			abort_r <= 1'b0;
			if (wr_hit && WB_SEL_I[0]) begin
				case (WB_ADR_I)
					`CTS_OFF_CTRL: begin
						start_r <= WB_DAT_I[`CTS_CTRL_START];
						abort_r <= WB_DAT_I[`CTS_CTRL_ABORT];
						large_r <= WB_DAT_I[`CTS_CTRL_SENSOR_LARGE];
						frames_r <= (WB_DAT_I[`CTS_CTRL_FRAMES_LSB +: 16] == 16'h0000) ? 16'h0001 :
							WB_DAT_I[`CTS_CTRL_FRAMES_LSB +: 16];
					end
					`CTS_OFF_MODE: begin
						resp_r <= WB_DAT_I[`CTS_MODE_RESP_LSB +: 3];
						edge_fall_r <= WB_DAT_I[`CTS_MODE_EDGE];
						rate_r <= WB_DAT_I[`CTS_MODE_RATE_LSB +: 2];
					end
					`CTS_OFF_ROWS: rows_r <= rows_wr;
					`CTS_OFF_ACCUM: accum_r <= (WB_DAT_I[15:0] == 16'h0000) ? 16'h0001 : WB_DAT_I[15:0];
					`CTS_OFF_DELAY: delay_r <= WB_DAT_I;
					`CTS_OFF_EXPOSE: expose_r <= WB_DAT_I;
					`CTS_OFF_READOUT: readout_r <= WB_DAT_I;
					`CTS_OFF_TRIGOUT: begin
						to0_r <= '{sel: cts_sel_e'(WB_DAT_I[`CTS_TO_SEL0_LSB +: 3]), invert: WB_DAT_I[`CTS_TO_INV0]};
						to1_r <= '{sel: cts_sel_e'(WB_DAT_I[`CTS_TO_SEL1_LSB +: 3]), invert: WB_DAT_I[`CTS_TO_INV1]};
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wb_dat_r <= 32'h0000_0000;
		end else if (rd_hit) begin
			case (WB_ADR_I)
				`CTS_OFF_CTRL: wb_dat_r <= {frames_r, 13'h0, large_r, 2'h0};
				`CTS_OFF_MODE: wb_dat_r <= {22'h0, rate_r, 3'h0, edge_fall_r, 1'b0, resp_r};
				`CTS_OFF_ROWS: wb_dat_r <= {24'h0, rows_r};
				`CTS_OFF_ACCUM: wb_dat_r <= {16'h0, accum_r};
				`CTS_OFF_DELAY: wb_dat_r <= delay_r;
				`CTS_OFF_EXPOSE: wb_dat_r <= expose_r;
				`CTS_OFF_READOUT: wb_dat_r <= readout_r;
				`CTS_OFF_TRIGOUT: wb_dat_r <= {19'h0, to1_r.invert, 1'b0, to1_r.sel, 3'h0, to0_r.invert, 1'b0, to0_r.sel};
				`CTS_OFF_STATUS: wb_dat_r <= {frame_r, 1'b0, state_r, 1'b0, dropped_r, stat};
				default: wb_dat_r <= 32'h0000_0000;
			endcase
		end
	end
	assign WB_DAT_O = wb_dat_r;

	// ----------------------------------------
	// trigger input
	// ----------------------------------------
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic rise_p;
	logic fall_p;
	logic trig_p;
	logic end_p;
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= TRIG_IN_I;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	assign rise_p = sync2_r && !sync3_r;
	assign fall_p = !sync2_r && sync3_r;
	assign trig_p = edge_fall_r ? fall_p : rise_p;
	assign end_p = edge_fall_r ? rise_p : fall_p;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic [31:0] cnt_r;
	logic [7:0] row_r;
	logic [1:0] step_r;
	logic [15:0] accd_r;
	logic [7:0] shift_cyc;
	logic last_step;
	logic last_row;
	logic cnt_done;

	always_comb begin
		case (rate_r)
			// reload value: one row spans SHn cycles
			2'h0: shift_cyc = 8'(SH0 - 1);
			2'h1: shift_cyc = 8'(SH1 - 1);
			2'h2: shift_cyc = 8'(SH2 - 1);
			default: shift_cyc = 8'(SH3 - 1);
		endcase
	end
	assign cnt_done = (cnt_r == 32'h0000_0000);
	assign last_row = (row_r == 8'h01);
	assign last_step = (step_r == 2'(`CTS_FRAMES_PER_READOUT - 1));

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_r <= CTS_ST_IDLE;
			cnt_r <= 32'h0000_0000;
			row_r <= 8'h00;
			step_r <= 2'h0;
			accd_r <= 16'h0000;
			frame_r <= 16'h0000;
			dropped_r <= 1'b0;
		end else if (abort_r) begin
			state_r <= CTS_ST_IDLE;
		end else begin
			if (trig_p && state_r != CTS_ST_WAIT && state_r != CTS_ST_IDLE && resp_r != CTS_RESP_NONE) begin
				dropped_r <= 1'b1;
			end
			if (!cnt_done) begin
				cnt_r <= cnt_r - 32'h0000_0001;
			end
			case (state_r)
				CTS_ST_IDLE: begin
					if (start_r) begin
						step_r <= 2'h0;
						accd_r <= 16'h0001;
						frame_r <= 16'h0000;
						dropped_r <= 1'b0;
						if (resp_r == CTS_RESP_NONE) begin
							state_r <= CTS_ST_EXPOSE;
							cnt_r <= expose_r;
						end else begin
							state_r <= CTS_ST_WAIT;
						end
					end
				end
				CTS_ST_WAIT: begin
					if (trig_p) begin
						state_r <= CTS_ST_DELAY;
						cnt_r <= 32'(({32'h0, delay_r} * 64'(CLK_HZ / 1000000) * 64'(DSTEP_NS)) / 64'd1000);
					end
				end
				CTS_ST_DELAY: begin
					if (cnt_done) begin
						if (resp_r == CTS_RESP_SHIFT && step_r == 2'(`CTS_FRAMES_PER_READOUT)) begin
							state_r <= CTS_ST_READ;
							cnt_r <= readout_r;
						end else if (resp_r == CTS_RESP_GATED) begin
							state_r <= CTS_ST_GATE;
						end else begin
							state_r <= CTS_ST_EXPOSE;
							cnt_r <= expose_r;
						end
					end
				end
				CTS_ST_GATE: begin
					if (end_p) begin
						state_r <= CTS_ST_SHIFT;
						row_r <= rows_r;
						cnt_r <= {24'h0, shift_cyc};
					end
				end
				CTS_ST_EXPOSE: begin
					if (cnt_done) begin
						state_r <= CTS_ST_SHIFT;
						row_r <= rows_r;
						cnt_r <= {24'h0, shift_cyc};
					end
				end
				CTS_ST_SHIFT: begin
					if (cnt_done) begin
						if (!last_row) begin
							row_r <= row_r - 8'h01;
							cnt_r <= {24'h0, shift_cyc};
						end else if (!last_step) begin
							step_r <= step_r + 2'h1;
							if (resp_r == CTS_RESP_SHIFT || resp_r == CTS_RESP_GATED) begin
								state_r <= CTS_ST_WAIT;
							end else begin
								state_r <= CTS_ST_EXPOSE;
								cnt_r <= expose_r;
							end
						end else if (accd_r != accum_r) begin
							accd_r <= accd_r + 16'h0001;
							step_r <= 2'h0;
							if (resp_r == CTS_RESP_SHIFT || resp_r == CTS_RESP_GATED) begin
								state_r <= CTS_ST_WAIT;
							end else begin
								state_r <= CTS_ST_EXPOSE;
								cnt_r <= expose_r;
							end
						end else if (resp_r == CTS_RESP_SHIFT) begin
							step_r <= 2'(`CTS_FRAMES_PER_READOUT);
							state_r <= CTS_ST_WAIT;
						end else begin
							state_r <= CTS_ST_READ;
							cnt_r <= readout_r;
						end
					end
				end
				CTS_ST_READ: begin
					if (cnt_done) begin
						frame_r <= frame_r + 16'h0001;
						step_r <= 2'h0;
						accd_r <= 16'h0001;
						if ((frame_r + 16'h0001) >= frames_r) begin
							state_r <= CTS_ST_IDLE;
						end else if (resp_r == CTS_RESP_NONE || resp_r == CTS_RESP_SINGLE) begin
							state_r <= CTS_ST_EXPOSE;
							cnt_r <= expose_r;
						end else begin
							state_r <= CTS_ST_WAIT;
						end
					end
				end
				default: state_r <= CTS_ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// status and trigger outputs
	// ----------------------------------------
	// status
	always_comb begin
		stat.acquiring = (state_r != CTS_ST_IDLE);
		stat.exposing = (state_r == CTS_ST_EXPOSE) || (state_r == CTS_ST_GATE);
		stat.reading = (state_r == CTS_ST_READ);
		stat.shifting = (state_r == CTS_ST_SHIFT);
		stat.shutter = stat.exposing || (resp_r == CTS_RESP_SHIFT && state_r != CTS_ST_IDLE && state_r != CTS_ST_READ);
		stat.waiting = (state_r == CTS_ST_WAIT);
	end

	function automatic logic pick(input cts_sel_e s, input cts_status_s st);
		case (s)
			CTS_SEL_ACQ: pick = st.acquiring;
			CTS_SEL_HIGH: pick = 1'b1;
			CTS_SEL_EXPOSE: pick = st.exposing;
			CTS_SEL_READ: pick = st.reading;
			CTS_SEL_SHIFT: pick = st.shifting;
			CTS_SEL_SHUTTER: pick = st.shutter;
			CTS_SEL_WAIT: pick = st.waiting;
			default: pick = 1'b0;
		endcase
	endfunction : pick

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			TRIG_OUT0_O <= 1'b0;
			TRIG_OUT1_O <= 1'b0;
		end else begin
			TRIG_OUT0_O <= pick(to0_r.sel, stat) ^ to0_r.invert;
			TRIG_OUT1_O <= pick(to1_r.sel, stat) ^ to1_r.invert;
		end
	end
endmodule : cts_sequencer

// ### design/cts_cfg.svh
// Purpose: constants for the camera trigger sequencer
// Assumes: 25 MHz system clock
// Notes: offsets are byte addresses on a 32-bit wishbone bus
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH
`define CTS_CLK_HZ 25000000
`define CTS_ADDR_W 6
// register offsets
`define CTS_OFF_CTRL 6'h00
`define CTS_OFF_MODE 6'h04
`define CTS_OFF_ROWS 6'h08
`define CTS_OFF_ACCUM 6'h0C
`define CTS_OFF_DELAY 6'h10
`define CTS_OFF_EXPOSE 6'h14
`define CTS_OFF_READOUT 6'h18
`define CTS_OFF_TRIGOUT 6'h1C
`define CTS_OFF_STATUS 6'h20
// control fields
`define CTS_CTRL_START 0
`define CTS_CTRL_ABORT 1
`define CTS_CTRL_SENSOR_LARGE 2
`define CTS_CTRL_FRAMES_LSB 16
// mode fields
`define CTS_MODE_RESP_LSB 0
`define CTS_MODE_EDGE 4
`define CTS_MODE_RATE_LSB 8
// trigger out fields
`define CTS_TO_SEL0_LSB 0
`define CTS_TO_INV0 4
`define CTS_TO_SEL1_LSB 8
`define CTS_TO_INV1 12
// reset values and row count limits
`define CTS_RST_ROWS 8'h01
`define CTS_RST_ACCUM 16'h0001
`define CTS_RST_FRAMES 16'h0001
`define CTS_RST_EXPOSE 32'h0000_0019
`define CTS_RST_READOUT 32'h0000_0019
`define CTS_ROWS_MAX_SMALL 8'h21
`define CTS_ROWS_MAX_LARGE 8'h85
// row shift times in ns
`define CTS_SHIFT_NS_0 750
`define CTS_SHIFT_NS_1 1000
`define CTS_SHIFT_NS_2 2000
`define CTS_SHIFT_NS_3 3000
// delay register step in ns, and frames exposed per readout
`define CTS_DELAY_STEP_NS 10
`define CTS_FRAMES_PER_READOUT 2
`endif

// ### design/cts_pkg.sv
// Purpose: types for the camera trigger sequencer
// Assumes: nothing
// Notes: one-hot state codes
package cts_pkg;
	typedef enum logic [2:0] {
		CTS_RESP_NONE = 3'h0,
		CTS_RESP_SINGLE = 3'h1,
		CTS_RESP_READOUT = 3'h2,
		CTS_RESP_SHIFT = 3'h3,
		CTS_RESP_GATED = 3'h4
	} cts_resp_e;
	typedef enum logic [2:0] {
		CTS_SEL_ACQ = 3'h0,
		CTS_SEL_HIGH = 3'h1,
		CTS_SEL_EXPOSE = 3'h2,
		CTS_SEL_READ = 3'h3,
		CTS_SEL_SHIFT = 3'h4,
		CTS_SEL_SHUTTER = 3'h5,
		CTS_SEL_WAIT = 3'h6
	} cts_sel_e;
	typedef enum logic [6:0] {
		CTS_ST_IDLE = 7'b000_0001,
		CTS_ST_WAIT = 7'b000_0010,
		CTS_ST_DELAY = 7'b000_0100,
		CTS_ST_EXPOSE = 7'b000_1000,
		CTS_ST_SHIFT = 7'b001_0000,
		CTS_ST_READ = 7'b010_0000,
		CTS_ST_GATE = 7'b100_0000
	} cts_state_e;
	typedef struct packed {
		logic acquiring;
		logic exposing;
		logic reading;
		logic shifting;
		logic shutter;
		logic waiting;
	} cts_status_s;
	typedef struct packed {
		cts_sel_e sel;
		logic invert;
	} cts_trigout_s;
endpackage : cts_pkg

// ### verification/cts_sequencer_asserts.sv
// Purpose: port checker for cts_sequencer
// Assumes: classic wishbone slave, registered trigger outputs
// Notes: trigger output setting is shadowed from bus writes
`timescale 1ns/100ps
`include "cts_cfg.svh"
module cts_sequencer_chk
	import cts_pkg::*;
#(
	parameter int CLK_HZ = `CTS_CLK_HZ
) (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [`CTS_ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic TRIG_IN_I,
	input wire logic TRIG_OUT0_O,
	input wire logic TRIG_OUT1_O
);
	logic take, wr, fresh_r;
	logic [2:0] quiet_r;
	logic [15:0] shadow_r;
	assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr = take && WB_WE_I && WB_SEL_I[0];
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			quiet_r <= 3'h0;
			fresh_r <= 1'b1;
		end else if (wr) begin
			quiet_r <= 3'h0;
			fresh_r <= 1'b0;
		end else if (quiet_r != 3'h7) begin
			quiet_r <= quiet_r + 3'h1;
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			shadow_r <= 16'h0000;
		end else if (wr && WB_ADR_I == `CTS_OFF_TRIGOUT) begin
			shadow_r <= WB_DAT_I[15:0];
		end
	end
	// ----------------------------
	// assertions
	// ----------------------------
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_N_I);
	ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	ack_after_take_a: assert property (take |=> WB_ACK_O)
		else $error("request not answered");
	ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("ack without request");
	unmapped_zero_a: assert property (take && !WB_WE_I && WB_ADR_I > `CTS_OFF_STATUS |=> WB_DAT_O == 32'h0000_0000)
		else $error("unmapped read not zero");
	read_hold_a: assert property (!(take && !WB_WE_I) |=> $stable(WB_DAT_O))
		else $error("read data moved");
	high_out0_a: assert property (
		quiet_r == 3'h7 && shadow_r[2:0] == CTS_SEL_HIGH |-> TRIG_OUT0_O == !shadow_r[4])
		else $error("output 0 not constant");
	high_out1_a: assert property (
		quiet_r == 3'h7 && shadow_r[10:8] == CTS_SEL_HIGH |-> TRIG_OUT1_O == !shadow_r[12])
		else $error("output 1 not constant");
	same_sel_a: assert property (
		quiet_r == 3'h7 && shadow_r[2:0] == shadow_r[10:8] |-> TRIG_OUT1_O == (TRIG_OUT0_O ^ shadow_r[4] ^ shadow_r[12]))
		else $error("invert mismatch");
	idle_low_a: assert property (fresh_r |-> !TRIG_OUT0_O && !TRIG_OUT1_O)
		else $error("outputs high while idle");
endmodule : cts_sequencer_chk
bind cts_sequencer cts_sequencer_chk #(.CLK_HZ(CLK_HZ)) chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TRIG_IN_I(TRIG_IN_I),
	.TRIG_OUT0_O(TRIG_OUT0_O), .TRIG_OUT1_O(TRIG_OUT1_O));

// ### verification/cts_trig_src.sv
// Purpose: external trigger source model
// Assumes: one pulse per fire request
// Notes: fire while busy is ignored
`timescale 1ns/100ps
module cts_trig_src (
	input wire logic clk_i,
	input wire logic fire_i,
	input wire logic active_low_i,
	input wire logic [15:0] width_i,
	output logic trig_o,
	output logic busy_o
);
	logic [15:0] cnt_r = 16'h0000;
	always_ff @(posedge clk_i) begin
		if (fire_i && cnt_r == 16'h0000) begin
			cnt_r <= width_i;
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end
	assign busy_o = cnt_r != 16'h0000;
	assign trig_o = busy_o ^ active_low_i;
endmodule : cts_trig_src

// ### verification/cts_sequencer_tb.sv
// Purpose: self-checking bench for cts_sequencer
// Assumes: trigger source model drives the pin
// Notes: exposure and readout registers stay at 4, five cycles each
`timescale 1ns/100ps
`include "cts_cfg.svh"
module cts_sequencer_tb
	import cts_pkg::*;
();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic fire = 1'b0;
	logic alow = 1'b0;
	logic ack, out0, out1, trig;
	logic [5:0] adr = 6'h00;
	logic [15:0] wid = 16'h0002;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] seed = 32'h0000_DA45;
	logic [31:0] rdat, q;
	logic [5:0] ra [5] = '{`CTS_OFF_ROWS, `CTS_OFF_ACCUM, `CTS_OFF_EXPOSE, `CTS_OFF_READOUT, 6'h24};
	logic [31:0] rv [5] = '{32'(`CTS_RST_ROWS), 32'(`CTS_RST_ACCUM), `CTS_RST_EXPOSE, `CTS_RST_READOUT, 32'h0000_0000};
	logic [31:0] cv [5] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0021, 32'h0000_0086, 32'h0000_00C8};
	int num_errors = 0;
	int samples_checked = 0;
	int hi0 = 0;
	int hi1 = 0;
	int n, base, w, d;
	int nfr = 1;
	// a count of 4 spans five cycles
	localparam int span_cyc = 5;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		hi0 += out0;
		hi1 += out1;
	end
	cts_sequencer dut (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.TRIG_IN_I(trig), .TRIG_OUT0_O(out0), .TRIG_OUT1_O(out1));
	cts_trig_src src (.clk_i(clk), .fire_i(fire), .active_low_i(alow), .width_i(wid), .trig_o(trig), .busy_o());
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] rows_exp(input logic [31:0] v, input logic big);
		logic [31:0] top;
		top = big ? 32'(`CTS_ROWS_MAX_LARGE) : 32'(`CTS_ROWS_MAX_SMALL);
		return (v == 0) ? 32'h0000_0001 : ((v > top) ? top : v);
	endfunction : rows_exp
	function automatic int dly_cycles(input int units);
		return units * `CTS_DELAY_STEP_NS / 40;
	endfunction : dly_cycles
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w_en, input logic [5:0] a, input logic [31:0] v);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_en;
		adr <= a;
		wd <= v;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic run(input logic [31:0] mode, input logic [31:0] sel);
		bus(1'b1, `CTS_OFF_CTRL, 32'h0000_0002);
		bus(1'b1, `CTS_OFF_MODE, mode);
		bus(1'b1, `CTS_OFF_TRIGOUT, sel);
		repeat (3) @(posedge clk);
		hi0 = 0;
		hi1 = 0;
		bus(1'b1, `CTS_OFF_CTRL, 32'(nfr << 16) | 32'h0000_0001);
	endtask : run
	task automatic pulse(input int width);
		wid <= 16'(width);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (width + 4) @(posedge clk);
	endtask : pulse
	// ----------------------------
	// scenarios
	// ----------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0000_0000);
			chk(q, rv[i]);
		end
		for (int b = 0; b < 2; b++) begin
			bus(1'b1, `CTS_OFF_CTRL, 32'(b << 2));
			foreach (cv[i]) begin
				bus(1'b1, `CTS_OFF_ROWS, cv[i]);
				bus(1'b0, `CTS_OFF_ROWS, 32'h0000_0000);
				chk(q, rows_exp(cv[i], b[0]));
			end
		end
		bus(1'b1, `CTS_OFF_ACCUM, 32'h0000_0000);
		bus(1'b0, `CTS_OFF_ACCUM, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		bus(1'b1, `CTS_OFF_ACCUM, 32'h0000_FFFF);
		bus(1'b0, `CTS_OFF_ACCUM, 32'h0000_0000);
		chk(q, 32'h0000_FFFF);
		bus(1'b1, `CTS_OFF_ACCUM, 32'h0000_0001);
		bus(1'b1, `CTS_OFF_EXPOSE, 32'h0000_0004);
		bus(1'b1, `CTS_OFF_READOUT, 32'h0000_0004);
		bus(1'b1, `CTS_OFF_ROWS, 32'h0000_0001);
		$display("test registers done");
		bus(1'b1, `CTS_OFF_TRIGOUT, 32'h0000_1101);
		repeat (8) @(posedge clk);
		chk(32'({out0, out1}), 32'h0000_0002);
		$display("test constant outputs done");
		run(32'h0000_0000, 32'h0000_0302);
		repeat (600) @(posedge clk);
		chk(32'(hi0), 32'(`CTS_FRAMES_PER_READOUT * span_cyc));
		chk(32'(hi1), 32'(span_cyc));
		bus(1'b0, `CTS_OFF_STATUS, 32'h0000_0000);
		chk(q >> 16, 32'h0000_0001);
		$display("test free run done");
		bus(1'b1, `CTS_OFF_ROWS, 32'h0000_0002);
		run(32'h0000_0300, 32'h0000_0004);
		repeat (600) @(posedge clk);
		chk(32'(hi0), 32'(`CTS_FRAMES_PER_READOUT * 2 * (`CTS_SHIFT_NS_3 / 40)));
		bus(1'b1, `CTS_OFF_ROWS, 32'h0000_0001);
		$display("test shift rate done");
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			d = (i == 0) ? 0 : 4 * int'(seed[6:0]);
			bus(1'b1, `CTS_OFF_DELAY, 32'(d));
			run(32'h0000_0001, 32'h0000_0602);
			repeat (10) @(posedge clk);
			chk(32'(out1), 32'h0000_0001);
			wid <= 16'h0002;
			fire <= 1'b1;
			n = 0;
			while (out0 !== 1'b1 && n < 900) begin
				@(posedge clk);
				fire <= 1'b0;
				n++;
			end
			chk(32'(n < 900), 32'h0000_0001);
			if (i == 0)
				base = n;
			chk(32'(n - base), 32'(dly_cycles(d)));
			repeat (300) @(posedge clk);
		end
		bus(1'b1, `CTS_OFF_DELAY, 32'h0000_0000);
		$display("test delay done");
		for (int e = 0; e < 2; e++) begin
			seed = xs(seed);
			w = 8 + int'(seed[4:0]);
			alow <= e[0];
			run(32'(4 + (e << 4)), 32'h0000_0002);
			pulse(w);
			repeat (200) @(posedge clk);
			pulse(w);
			repeat (400) @(posedge clk);
			chk(32'(hi0), 32'(2 * (w - 1)));
		end
		alow <= 1'b0;
		$display("test gated done");
		run(32'h0000_0002, 32'h0000_0003);
		pulse(2);
		pulse(2);
		repeat (400) @(posedge clk);
		chk(32'(hi0), 32'(span_cyc));
		bus(1'b0, `CTS_OFF_STATUS, 32'h0000_0000);
		chk(32'(q[6]), 32'h0000_0001);
		$display("test busy drop done");
		nfr = 2;
		run(32'h0000_0001, 32'h0000_0003);
		pulse(2);
		repeat (300) @(posedge clk);
		chk(32'(hi0), 32'(2 * span_cyc));
		run(32'h0000_0002, 32'h0000_0003);
		pulse(2);
		repeat (300) @(posedge clk);
		chk(32'(hi0), 32'(span_cyc));
		chk(32'(out1), 32'h0000_0001);
		pulse(2);
		repeat (300) @(posedge clk);
		chk(32'(hi0), 32'(2 * span_cyc));
		bus(1'b0, `CTS_OFF_STATUS, 32'h0000_0000);
		chk(q >> 16, 32'h0000_0002);
		nfr = 1;
		$display("test frame repeat done");
		run(32'h0000_0003, 32'h0000_0003);
		pulse(2);
		repeat (300) @(posedge clk);
		chk(32'(hi0), 32'h0000_0000);
		repeat (4) begin
			pulse(2);
			repeat (300) @(posedge clk);
		end
		chk(32'(hi0), 32'(span_cyc));
		$display("test shift steps done");
		summarize();
	end
	initial begin
		#(40 * 30000);
		num_errors++;
		summarize();
	end
endmodule : cts_sequencer_tb
